// *** hw/iso_shift_unit.sv ***
`timescale 1ns/1ns
`default_nettype none
module iso_shift_unit (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // From the instruction decoder
  input wire logic [31:0] operand_i,
  input wire logic [1:0] shift_type_i,
  input wire logic [4:0] shift_amount_field_i,
  input wire logic carry_i,
  input wire logic valid_i,
  // To the arithmetic unit
  output logic [31:0] result_o,
  output logic carry_o,
  output logic [31:0] value_o,
  output logic valid_o
);

  // Software-side state
  // Lets software exercise the shifter when no decoder is attached
  logic [8:0] ctrl_q;
  logic [31:0] operand_q;
  logic [31:0] reg_rdata_q;
  logic sw_kick_q;

  // Result registers
  // Kind and amount are kept only so software can read them back
  logic [31:0] result_q;
  logic carry_q;
  logic valid_q;
  iso_pkg::iso_kind_t kind_q;
  logic [5:0] amount_q;

  // Selected inputs
  logic use_sw;
  logic [31:0] sel_operand;
  logic sel_carry;
  logic [32:0] shift_d;

  // Fields cross to the decoder and back through one carrier
  iso_dec_if dec_bus ();

  // Barrel shift, carry in the top bit of the answer
  function automatic logic [32:0] shift_c(
    input logic [31:0] v,
    input iso_pkg::iso_kind_t kind,
    input logic [5:0] amt,
    input logic cin
  );
    logic [32:0] wide;
    logic signed [32:0] swide;
    logic [31:0] rot;
    logic [5:0] back;
    wide = 33'h0_0000_0000;
    swide = 33'sh0_0000_0000;
    rot = 32'h0000_0000;
    back = iso_pkg::AMT_ZERO;
    if (amt == iso_pkg::AMT_ZERO) begin
      shift_c = {cin, v}; // RQ6
    end else begin
      case (kind)
        iso_pkg::kind_left_logical: begin
          // Amount never exceeds 31 here, the source cannot encode more
          wide = {1'b0, v} << amt; // RQ10
          shift_c = wide; // RQ11
        end
        iso_pkg::kind_right_logical: begin
          // Spare low bit catches the last bit out, also at 32
          wide = {v, 1'b0} >> amt; // RQ11
          shift_c = {wide[0], wide[32:1]}; // RQ12
        end
        iso_pkg::kind_right_arithmetic: begin
          swide = $signed({v, 1'b0}) >>> amt; // RQ11
          shift_c = {swide[0], swide[32:1]}; // RQ12
        end
        iso_pkg::kind_rotate: begin
          // A zero field never gets here; it took the extend form
          back = iso_pkg::AMT_FULL - amt;
          rot = (v >> amt) | (v << back); // RQ11
          shift_c = {rot[31], rot};
        end
        iso_pkg::kind_rotate_extend: begin
          shift_c = {v[0], cin, v[31:1]}; // RQ7
        end
        default: begin
          shift_c = {cin, v};
        end
      endcase
    end
  endfunction

  // Write strobe aimed at one register offset
  function automatic logic wr_hit(
    input logic wr,
    input logic [7:0] addr,
    input logic [7:0] ofs
  );
    wr_hit = wr && (addr == ofs);
  endfunction

  // Status word, each field at its own position
  function automatic logic [31:0] status_word(
    input logic [31:0] res,
    input iso_pkg::iso_kind_t kind,
    input logic [5:0] amt,
    input logic cout
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    w[iso_pkg::STAT_CARRY_BIT] = cout;
    w[iso_pkg::STAT_KIND_LSB +: 3] = kind;
    w[iso_pkg::STAT_AMT_LSB +: iso_pkg::AMT_W] = amt;
    w[iso_pkg::STAT_ZERO_BIT] = (res == 32'h0000_0000);
    status_word = w;
  endfunction

  // Source select: pins normally, registers for software tests
  assign use_sw = ctrl_q[iso_pkg::CTRL_SRC_BIT];
  assign sel_operand = use_sw ? operand_q : operand_i;
  assign sel_carry = use_sw ? ctrl_q[iso_pkg::CTRL_CARRY_BIT] : carry_i;
  assign dec_bus.shift_type = use_sw ?
      ctrl_q[iso_pkg::CTRL_TYPE_LSB +: iso_pkg::TYPE_W] : shift_type_i;
  assign dec_bus.shift_amount_field = use_sw ?
      ctrl_q[iso_pkg::CTRL_FIELD_LSB +: iso_pkg::FIELD_W] : shift_amount_field_i;

  // Field decoding
  iso_shift_field_decoder u_decoder (
    .dec(dec_bus.decoder)
  );

  // One shifter serves both outputs
  assign shift_d = shift_c(sel_operand, dec_bus.kind, dec_bus.amount, sel_carry);

  // Control register, written by software
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= iso_pkg::CTRL_RESET; // RQ1
    end else if (wr_hit(reg_wr_i, reg_addr_i, iso_pkg::OFS_CTRL)) begin
      ctrl_q <= reg_wdata_i[8:0];
    end
  end

  // Operand register, written by software
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      operand_q <= iso_pkg::OPERAND_RESET;
    end else if (wr_hit(reg_wr_i, reg_addr_i, iso_pkg::OFS_OPERAND)) begin
      operand_q <= reg_wdata_i;
    end
  end

  // A control or operand write starts one result in software mode, seen a cycle later
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sw_kick_q <= 1'b0;
    end else begin
      sw_kick_q <= wr_hit(reg_wr_i, reg_addr_i, iso_pkg::OFS_CTRL) ||
          wr_hit(reg_wr_i, reg_addr_i, iso_pkg::OFS_OPERAND);
    end
  end

  // Result stage, refreshed every cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      result_q <= 32'h0000_0000;
      carry_q <= 1'b0;
      kind_q <= iso_pkg::kind_left_logical;
      amount_q <= iso_pkg::AMT_ZERO;
    end else begin
      result_q <= shift_d[31:0];
      carry_q <= shift_d[32];
      kind_q <= dec_bus.kind;
      amount_q <= dec_bus.amount;
    end
  end

  // Valid follows the active source
  // In software mode a register write is the only request there is
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= use_sw ? sw_kick_q : valid_i;
    end
  end

  // Read data stand for the one cycle after the strobe
  // Unmapped offsets read as zero rather than stale data
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_q <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        iso_pkg::OFS_CTRL: reg_rdata_q <= {23'h00_0000, ctrl_q};
        iso_pkg::OFS_OPERAND: reg_rdata_q <= operand_q;
        iso_pkg::OFS_RESULT: reg_rdata_q <= result_q;
        iso_pkg::OFS_STATUS: reg_rdata_q <= status_word(result_q, kind_q, amount_q, carry_q);
        default: reg_rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_q <= 32'h0000_0000;
    end
  end

  // Both output forms share one register; the value form drops carry
  // A consumer that ignores carry simply leaves carry_o open
  assign result_o = result_q; // RQ9
  assign carry_o = carry_q;
  assign value_o = result_q; // RQ9
  assign valid_o = valid_q;
  assign reg_rdata_o = reg_rdata_q;

endmodule
`default_nettype wire

// *** hw/iso_pkg.sv ***
// Functional notes
// RQ1 - No shift requested means a logical left shift by zero: type 00, field 0.
// RQ2 - Type 00 decodes logical left, amount equals the five-bit field.
// RQ3 - Type 01 decodes logical right, amount is the field, zero meaning 32.
// RQ4 - Type 10 decodes arithmetic right, amount is the field, zero meaning 32.
// RQ5 - Type 11 with zero field is rotate-with-extend by one, else rotate right.
// RQ6 - Amount zero passes operand and incoming carry through unchanged.
// RQ7 - Rotate-with-extend: carry-out is bit 0, carry-in enters bit 31.
// RQ8 - Rotate-with-extend only ever pairs with amount one.
// RQ9 - Two outputs: shifted value with carry, and value alone.
// RQ10 - Source never asks logical left by 32 or more.
// RQ11 - Carry-out is last bit shifted out; fills are zero, sign or wrapped bits.
// RQ12 - Shift by 32: logical right gives zero, arithmetic gives sign; carry is bit 31.
package iso_pkg;

  // Datapath widths
  localparam int WORD_W = 32;
  localparam int AMT_W = 6;
  localparam int FIELD_W = 5;
  localparam int TYPE_W = 2;
  localparam int ADDR_W = 8;

  // Shift-type encodings
  localparam logic [1:0] TYPE_LEFT = 2'h0;
  localparam logic [1:0] TYPE_RIGHT = 2'h1;
  localparam logic [1:0] TYPE_ARITH = 2'h2;
  localparam logic [1:0] TYPE_ROT = 2'h3;

  // Special amounts
  localparam logic [5:0] AMT_ZERO = 6'h00;
  localparam logic [5:0] AMT_ONE = 6'h01;
  localparam logic [5:0] AMT_FULL = 6'h20;
  localparam logic [4:0] FIELD_ZERO = 5'h00;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_OPERAND = 8'h04;
  localparam logic [7:0] OFS_RESULT = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;

  // Control register fields
  localparam int CTRL_FIELD_LSB = 0;
  localparam int CTRL_TYPE_LSB = 5;
  localparam int CTRL_CARRY_BIT = 7;
  localparam int CTRL_SRC_BIT = 8;
  localparam logic [8:0] CTRL_RESET = 9'h000;
  localparam logic [31:0] OPERAND_RESET = 32'h0000_0000;

  // Status register fields
  localparam int STAT_CARRY_BIT = 0;
  localparam int STAT_KIND_LSB = 1;
  localparam int STAT_AMT_LSB = 4;
  localparam int STAT_ZERO_BIT = 10;

  // Decoded shift kinds
  typedef enum logic [2:0] {
    kind_left_logical = 3'b000,
    kind_right_logical = 3'b001,
    kind_right_arithmetic = 3'b010,
    kind_rotate = 3'b011,
    kind_rotate_extend = 3'b100
  } iso_kind_t;

endpackage

// *** hw/iso_dec_if.sv ***
`timescale 1ns/1ns
`default_nettype none
// Fields in, decoded kind and amount out
interface iso_dec_if;
  logic [1:0] shift_type;
  logic [4:0] shift_amount_field;
  iso_pkg::iso_kind_t kind;
  logic [5:0] amount;

  modport decoder (
    input shift_type,
    input shift_amount_field,
    output kind,
    output amount
  );
  modport user (
    output shift_type,
    output shift_amount_field,
    input kind,
    input amount
  );
endinterface
`default_nettype wire

// *** hw/iso_shift_field_decoder.sv ***
`timescale 1ns/1ns
`default_nettype none
module iso_shift_field_decoder (
  iso_dec_if.decoder dec
);

  logic [5:0] field_amt;
  logic field_is_zero;

  // Widen the field once
  assign field_amt = {1'b0, dec.shift_amount_field};
  assign field_is_zero = (dec.shift_amount_field == iso_pkg::FIELD_ZERO);

  // Type and field to kind and amount
  always_comb begin
    case (dec.shift_type)
      iso_pkg::TYPE_LEFT: begin
        dec.kind = iso_pkg::kind_left_logical; // RQ2
        dec.amount = field_amt; // RQ1
      end
      iso_pkg::TYPE_RIGHT: begin
        dec.kind = iso_pkg::kind_right_logical;
        dec.amount = field_is_zero ? iso_pkg::AMT_FULL : field_amt; // RQ3
      end
      iso_pkg::TYPE_ARITH: begin
        dec.kind = iso_pkg::kind_right_arithmetic;
        dec.amount = field_is_zero ? iso_pkg::AMT_FULL : field_amt; // RQ4
      end
      iso_pkg::TYPE_ROT: begin
        if (field_is_zero) begin
          // Extend form is only ever paired with one
          dec.kind = iso_pkg::kind_rotate_extend; // RQ5
          dec.amount = iso_pkg::AMT_ONE; // RQ8
        end else begin
          dec.kind = iso_pkg::kind_rotate; // RQ5
          dec.amount = field_amt;
        end
      end
      default: begin
        dec.kind = iso_pkg::kind_left_logical;
        dec.amount = iso_pkg::AMT_ZERO;
      end
    endcase
  end

endmodule
`default_nettype wire

// *** tb/iso_unit_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
module iso_unit_checker (
  // Clock, reset and register port
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // Datapath
  input wire logic [31:0] operand_i,
  input wire logic [1:0] shift_type_i,
  input wire logic [4:0] shift_amount_field_i,
  input wire logic carry_i,
  input wire logic valid_i,
  input wire logic [31:0] result_o,
  input wire logic carry_o,
  input wire logic [31:0] value_o,
  input wire logic valid_o
);
  logic sw_q;
  logic [5:0] amt;
  logic [4:0] lo;
  logic [31:0] sra_w;
  logic [31:0] rot_w;
  // Track the source bit, since pins are ignored in software mode
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sw_q <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == 8'h00) begin
      sw_q <= reg_wdata_i[8];
    end
  end
  // Zero field reads as 32 on right shifts; lo indexes the last bit out
  assign amt = {shift_amount_field_i == 5'h00, shift_amount_field_i};
  assign lo = shift_amount_field_i - 5'h01;
  assign sra_w = $signed(operand_i) >>> amt;
  assign rot_w = (operand_i >> shift_amount_field_i) | (operand_i << (6'h20 - amt));
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  value_form_a: assert property (
    value_o == result_o) else $error("value form differs");
  pass_zero_a: assert property (
    !sw_q && shift_type_i == 2'h0 && lo == 5'h1F
    |=> result_o == $past(operand_i) && carry_o == $past(carry_i)) else $error("no shift wrong");
  left_shift_a: assert property (
    !sw_q && shift_type_i == 2'h0 && lo != 5'h1F
    |=> result_o == $past(operand_i << shift_amount_field_i) && carry_o == $past(operand_i[~lo]))
    else $error("left shift wrong");
  right_logic_a: assert property (
    !sw_q && shift_type_i == 2'h1
    |=> result_o == $past(operand_i >> amt) && carry_o == $past(operand_i[lo]))
    else $error("right shift wrong");
  right_arith_a: assert property (
    !sw_q && shift_type_i == 2'h2 |=> result_o == $past(sra_w) && carry_o == $past(operand_i[lo]))
    else $error("arith shift wrong");
  rotate_a: assert property (
    !sw_q && shift_type_i == 2'h3 && lo != 5'h1F |=> result_o == $past(rot_w) && carry_o == result_o[31])
    else $error("rotate wrong");
  rotate_ext_a: assert property (
    !sw_q && shift_type_i == 2'h3 && lo == 5'h1F
    |=> result_o == {$past(carry_i), $past(operand_i[31:1])} && carry_o == $past(operand_i[0]))
    else $error("extend rotate wrong");
  valid_delay_a: assert property (
    !sw_q |=> valid_o == $past(valid_i)) else $error("valid not delayed");
  rdata_idle_a: assert property (
    !reg_rd_i |=> reg_rdata_o == 32'h0) else $error("read data not idle");
endmodule
`default_nettype wire

// *** tb/iso_src_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module iso_src_model (
  // Clock
  input wire logic clk_i,
  // Toward the shifter
  output logic [31:0] operand_o,
  output logic [1:0] shift_type_o,
  output logic [4:0] field_o,
  output logic carry_o,
  output logic valid_o
);
  // Quiet source at time zero
  initial begin
    operand_o = 32'h0;
    shift_type_o = 2'h0;
    field_o = 5'h00;
    carry_o = 1'b0;
    valid_o = 1'b0;
  end
  // Five-bit field cannot ask a left shift of 32
  task automatic issue(input logic [31:0] op, input logic [1:0] t, input logic [4:0] f,
                       input logic c);
    @(posedge clk_i);
    operand_o <= op;
    shift_type_o <= t;
    field_o <= f;
    carry_o <= c;
    valid_o <= 1'b1;
  endtask
  // Idle scrambles the operand so stale data cannot pass for fresh
  task automatic idle();
    @(posedge clk_i);
    operand_o <= ~operand_o;
    valid_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** tb/iso_shift_unit_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module iso_shift_unit_bench;
  localparam logic [31:0] A = 32'h8000_0001;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o, operand, result_o, value_o;
  logic [1:0] ty;
  logic [4:0] fld;
  logic cin, vin, carry_o, valid_o;
  int miscompares = 0;
  int checked = 0;
  // Free-running clock
  always #5 clk_i = ~clk_i;
  iso_src_model src (.clk_i(clk_i), .operand_o(operand), .shift_type_o(ty), .field_o(fld),
    .carry_o(cin), .valid_o(vin));
  iso_shift_unit uut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .operand_i(operand), .shift_type_i(ty),
    .shift_amount_field_i(fld), .carry_i(cin), .valid_i(vin), .result_o(result_o),
    .carry_o(carry_o), .value_o(value_o), .valid_o(valid_o));
  // Verdict and end of run
  task automatic wrap_up();
    if (miscompares == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Register port: one-cycle strobes, data the cycle after a read
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 cmp(reg_rdata_o, exp);
  endtask
  // One pin request, answer checked one cycle later
  task automatic vec(input logic [31:0] op, input logic [1:0] t, input logic [4:0] f,
                     input logic c, input logic [31:0] er, input logic ec);
    src.issue(op, t, f, c);
    @(posedge clk_i);
    #1 cmp(result_o, er);
    cmp(value_o, er);
    cmp({30'h0, carry_o, valid_o}, {30'h0, ec, 1'b1});
  endtask
  // Hang guard
  initial begin
    repeat (2000) @(posedge clk_i);
    miscompares++;
    wrap_up();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h40, 32'h0);
    vec(A, 2'h0, 5'h00, 1'b1, A, 1'b1);
    vec(A, 2'h0, 5'h01, 1'b0, 32'h0000_0002, 1'b1);
    vec(A, 2'h0, 5'h1F, 1'b0, 32'h8000_0000, 1'b0);
    vec(A, 2'h1, 5'h01, 1'b0, 32'h4000_0000, 1'b1);
    vec(A, 2'h1, 5'h00, 1'b0, 32'h0, 1'b1);
    vec(A, 2'h2, 5'h04, 1'b0, 32'hF800_0000, 1'b0);
    vec(A, 2'h2, 5'h00, 1'b0, 32'hFFFF_FFFF, 1'b1);
    vec(32'h7000_0000, 2'h2, 5'h00, 1'b1, 32'h0, 1'b0);
    vec(A, 2'h3, 5'h01, 1'b0, 32'hC000_0000, 1'b1);
    vec(A, 2'h3, 5'h1F, 1'b0, 32'h0000_0003, 1'b0);
    vec(A, 2'h3, 5'h00, 1'b0, 32'h4000_0000, 1'b1);
    src.idle();
    @(posedge clk_i);
    #1 cmp({31'h0, valid_o}, 32'h0);
    // Software source: extend rotate of 3 with carry in set
    wr(8'h04, 32'h0000_0003);
    wr(8'h00, 32'h0000_01E0);
    @(posedge clk_i);
    #1 cmp({31'h0, valid_o}, 32'h1);
    wr(8'h08, 32'hFFFF_FFFF);
    rd(8'h08, 32'h8000_0001);
    rd(8'h0C, 32'h0000_0019);
    rd(8'h00, 32'h0000_01E0);
    // Software source: logical right by 32 gives zero, status shows it
    wr(8'h00, 32'h0000_0120);
    rd(8'h08, 32'h0);
    rd(8'h0C, 32'h0000_0602);
    wr(8'h00, 32'h0);
    wrap_up();
  end
endmodule
bind iso_shift_unit iso_unit_checker chk (.clk_i(clk_i), .rst_i(rst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .operand_i(operand_i),
  .shift_type_i(shift_type_i), .shift_amount_field_i(shift_amount_field_i),
  .carry_i(carry_i), .valid_i(valid_i), .result_o(result_o), .carry_o(carry_o),
  .value_o(value_o), .valid_o(valid_o));
`default_nettype wire
